// [rtl/serial_cfg.svh]
// register offsets, reset values and field positions of the serial unit
// assumes inclusion by bare name from the baud_tick and async_serial_unit modules
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH
`define OFS_STATUS 3'h0
`define OFS_DATA 3'h1
`define OFS_BAUD 3'h2
`define OFS_CTRL1 3'h3
`define OFS_CTRL2 3'h4
`define OFS_TXFINE 3'h5
`define OFS_RXFINE 3'h6
`define RST_STATUS 8'hC0
`define RST_CTRL 8'h00
`define RST_BAUD 8'h00
`define OVERSAMPLE 5'h10
`define MID_SAMPLE_A 4'h7
`define MID_SAMPLE_C 4'h9
// ctrl1 fields
`define C1_T8 6
`define C1_WORD9 4
`define C1_WAKE 3
`define C1_PAR_ON 2
`define C1_PAR_SENSE 1
`define C1_PAR_IRQ 0
// ctrl2 fields
`define C2_TXE_IRQ 7
`define C2_TC_IRQ 6
`define C2_RX_IRQ 5
`define C2_IDLE_IRQ 4
`define C2_TX_ON 3
`define C2_RX_ON 2
`define C2_MUTE 1
`define C2_BREAK 0
`endif

// [rtl/serial_pkg.sv]
// shared types of the serial unit
// assumes serial_cfg.svh holds the numbers
package serial_pkg;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
    typedef struct packed {
        logic [1:0] prescale_sel;
        logic [2:0] divide_sel;
        logic [7:0] fine;
    } rate_cfg_t;
endpackage

// [rtl/baud_tick.sv]
// one direction's 16x baud enable: prescaler, power of two, fine divider
// assumes settings stay fixed while the direction is enabled
`timescale 1ns/100ps
`include "serial_cfg.svh"
module baud_tick (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire serial_pkg::rate_cfg_t cfg_i,
    output logic tick_o
);
    logic [3:0] pre_ff;
    logic [6:0] pow_ff;
    logic [7:0] fine_ff;
    logic [3:0] pre_max;
    logic [6:0] pow_max;
    logic pre_hit;
    logic pow_hit;
    always_comb
    begin
        unique case (cfg_i.prescale_sel)
            2'h0: pre_max = 4'h0;
            2'h1: pre_max = 4'h2;
            2'h2: pre_max = 4'h3;
            default: pre_max = 4'hC;
        endcase
        pow_max = 7'((8'h01 << cfg_i.divide_sel) - 8'h01);
    end
    assign pre_hit = (pre_ff == pre_max);
    assign pow_hit = pre_hit && (pow_ff == pow_max);
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            pre_ff <= 4'h0;
        else if (pre_hit)
            pre_ff <= 4'h0;
        else
            pre_ff <= pre_ff + 4'h1;
    end
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            pow_ff <= 7'h00;
        else if (pow_hit)
            pow_ff <= 7'h00;
        else if (pre_hit)
            pow_ff <= pow_ff + 7'h01;
    end
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            fine_ff <= 8'h00;
        else if (pow_hit)
            fine_ff <= (fine_ff + 8'h01 >= cfg_i.fine) ? 8'h00 : fine_ff + 8'h01;
    end
    // zero fine setting bypasses the extended stage
    assign tick_o = pow_hit && (cfg_i.fine == 8'h00 || fine_ff + 8'h01 >= cfg_i.fine);
endmodule

// [rtl/frame_tx.sv]
// transmit shifter: data, idle and break frames at 16x tick
// assumes the caller offers a frame only when ready
`timescale 1ns/100ps
module frame_tx (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic [10:0] frame_i,
    input wire logic [3:0] nbits_i,
    output logic busy_o,
    output logic done_o,
    output logic pin_o
);
    logic [10:0] sh_ff;
    logic [3:0] left_ff;
    logic [3:0] sub_ff;
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            sh_ff <= 11'h7FF;
            left_ff <= 4'h0;
            sub_ff <= 4'h0;
        end
        // reload on the last tick so back-to-back frames leave no mark gap
        else if (start_i && (!busy_o || done_o))
        begin
            sh_ff <= frame_i;
            left_ff <= nbits_i;
            sub_ff <= 4'h0;
        end
        else if (busy_o && tick_i)
        begin
            sub_ff <= sub_ff + 4'h1;
            if (sub_ff == 4'hF)
            begin
                sh_ff <= {1'b1, sh_ff[10:1]};
                left_ff <= left_ff - 4'h1;
            end
        end
    end
    assign busy_o = (left_ff != 4'h0);
    assign done_o = busy_o && tick_i && sub_ff == 4'hF && left_ff == 4'h1;
    assign pin_o = busy_o ? sh_ff[0] : 1'b1;
endmodule

// [rtl/async_serial_unit.sv]
// async serial unit core: register port, transmitter control, receiver
// assumes a one-cycle read/write strobe master and a pin synchronous to clock_i
`timescale 1ns/100ps
`include "serial_cfg.svh"
module async_serial_unit (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire serial_pkg::bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic irq_o
);
    typedef enum logic [3:0] {
        RX_HUNT = 4'b0001,
        RX_START = 4'b0010,
        RX_BITS = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;

    logic [7:0] ctrl1_ff, ctrl2_ff, baud_ff, txfine_ff, rxfine_ff;
    logic tx_buffer_empty_ff, tx_done_flag_ff, rx_buffer_full_ff, idle_ff;
    logic overrun_ff, noise_flag_ff, framing_flag_ff, parity_fail_flag_ff;
    logic status_seen_ff, hidden_noise_ff, idle_armed_ff;
    logic [8:0] tx_buffer_ff, rx_buffer_ff;
    logic tx_pending_ff, idle_due_ff, break_tail_ff;
    logic [7:0] rdata_ff;
    logic tx_tick, rx_tick, tx_busy, tx_done, tx_start;
    logic [10:0] tx_frame;
    logic [3:0] tx_len;
    logic word9, rd_data, wr_data, rd_status;
    assign word9 = ctrl1_ff[`C1_WORD9];
    assign rd_status = bus_i.rd && bus_i.addr == `OFS_STATUS;
    assign rd_data = bus_i.rd && bus_i.addr == `OFS_DATA;
    assign wr_data = bus_i.wr && bus_i.addr == `OFS_DATA;

    baud_tick u_tx_rate (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .cfg_i({baud_ff[7:6], baud_ff[5:3], txfine_ff}),
        .tick_o(tx_tick)
    );
    baud_tick u_rx_rate (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .cfg_i({baud_ff[7:6], baud_ff[2:0], rxfine_ff}),
        .tick_o(rx_tick)
    );
    // relied on: rate dividers are not restarted on setting changes

    // register writes
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            ctrl1_ff <= `RST_CTRL;
            baud_ff <= `RST_BAUD;
            txfine_ff <= `RST_BAUD;
            rxfine_ff <= `RST_BAUD;
        end
        else if (bus_i.wr)
        begin
            if (bus_i.addr == `OFS_CTRL1)
                ctrl1_ff <= bus_i.wdata;
            if (bus_i.addr == `OFS_BAUD)
                baud_ff <= bus_i.wdata;
            if (bus_i.addr == `OFS_TXFINE)
                txfine_ff <= bus_i.wdata;
            if (bus_i.addr == `OFS_RXFINE)
                rxfine_ff <= bus_i.wdata;
        end
    end

    // receiver
    rx_state_t rx_st_ff;
    logic [3:0] rx_sub_ff, rx_cnt_ff;
    logic [2:0] hist_ff;
    logic [2:0] mid_ff;
    logic [8:0] rx_sh_ff;
    logic rx_noise_ff, rx_ones_ff, rx_zeros_ff;
    logic mute_clear, rx_done, rx_idle_done, maj, noisy, stop_bad;
    logic [3:0] rx_len;
    logic parity_bad, addr_mark, accept, flags_ok;
    assign rx_len = word9 ? 4'h9 : 4'h8;
    assign maj = (mid_ff[0] & mid_ff[1]) | (mid_ff[0] & serial_in_pin_i) | (mid_ff[1] & serial_in_pin_i);
    assign noisy = !(mid_ff[0] == mid_ff[1] && mid_ff[1] == serial_in_pin_i);
    logic sample_end;
    assign sample_end = rx_tick && rx_sub_ff == `MID_SAMPLE_C;

    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            mid_ff <= 3'h0;
        else if (rx_tick && (rx_sub_ff == `MID_SAMPLE_A || rx_sub_ff == 4'h8))
            mid_ff <= {mid_ff[1:0], serial_in_pin_i};
    end

    always_ff @(posedge clock_i)
    begin
        // reset to mark level so no false noise mark follows reset
        if (!rstn_i)
            hist_ff <= 3'h7;
        else if (rx_tick)
            hist_ff <= {hist_ff[1:0], serial_in_pin_i};
    end

    always_ff @(posedge clock_i)
    begin
        if (!rstn_i || !ctrl2_ff[`C2_RX_ON])
        begin
            rx_st_ff <= RX_HUNT;
            rx_sub_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
            rx_sh_ff <= 9'h000;
            rx_noise_ff <= 1'b0;
            rx_ones_ff <= 1'b1;
            rx_zeros_ff <= 1'b1;
        end
        else if (rx_tick)
        begin
            rx_sub_ff <= rx_sub_ff + 4'h1;
            unique case (rx_st_ff)
                RX_HUNT:
                begin
                    rx_sub_ff <= 4'h1;
                    if (!serial_in_pin_i)
                    begin
                        rx_st_ff <= RX_START;
                        rx_noise_ff <= (hist_ff != 3'h7);
                    end
                end
                RX_START:
                    if (sample_end)
                    begin
                        if (maj)
                            rx_st_ff <= RX_HUNT;
                        else
                        begin
                            rx_noise_ff <= rx_noise_ff | noisy;
                            rx_st_ff <= RX_BITS;
                            rx_cnt_ff <= 4'h0;
                            rx_ones_ff <= 1'b1;
                            rx_zeros_ff <= 1'b1;
                        end
                    end
                RX_BITS:
                    if (sample_end)
                    begin
                        rx_sh_ff <= word9 ? {maj, rx_sh_ff[8:1]} : {1'b0, maj, rx_sh_ff[7:1]};
                        rx_noise_ff <= rx_noise_ff | noisy;
                        rx_ones_ff <= rx_ones_ff & maj;
                        rx_zeros_ff <= rx_zeros_ff & !maj;
                        rx_cnt_ff <= rx_cnt_ff + 4'h1;
                        if (rx_cnt_ff == rx_len - 4'h1)
                            rx_st_ff <= RX_STOP;
                    end
                RX_STOP:
                    if (sample_end)
                        rx_st_ff <= RX_HUNT;
            endcase
        end
    end

    // false start keeps a noise mark for the next frame
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            hidden_noise_ff <= 1'b0;
        else if (rx_st_ff == RX_START && sample_end && maj)
            hidden_noise_ff <= 1'b1;
        else if (rx_done)
            hidden_noise_ff <= 1'b0;
    end

    logic frame_end;
    assign frame_end = rx_st_ff == RX_STOP && sample_end && ctrl2_ff[`C2_RX_ON];
    assign stop_bad = !maj;
    assign rx_idle_done = frame_end && rx_ones_ff && maj && idle_armed_ff;
    assign rx_done = frame_end && !(rx_ones_ff && maj);
    assign parity_bad = ctrl1_ff[`C1_PAR_ON] && (^rx_sh_ff[8:0] != ctrl1_ff[`C1_PAR_SENSE]);
    assign addr_mark = word9 ? rx_sh_ff[8] : rx_sh_ff[7];
    // while muted only an address mark gets through, and only with address-mark wake
    assign accept = rx_done && (!ctrl2_ff[`C2_MUTE] || (ctrl1_ff[`C1_WAKE] && addr_mark));
    assign flags_ok = accept && !rx_buffer_full_ff;
    assign mute_clear = ctrl2_ff[`C2_MUTE] && ((rx_idle_done && !ctrl1_ff[`C1_WAKE]) ||
                        (rx_done && ctrl1_ff[`C1_WAKE] && addr_mark));

    // read-then-clear sequence arming
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            status_seen_ff <= 1'b0;
        else if (rd_status)
            status_seen_ff <= 1'b1;
        else if (rd_data || wr_data)
            status_seen_ff <= 1'b0;
    end
    logic rx_clear, tx_clear;
    assign rx_clear = status_seen_ff && rd_data;
    assign tx_clear = status_seen_ff && wr_data;

    // receive flags: hardware set wins over the clear sequence
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            rx_buffer_full_ff <= 1'b0;
            overrun_ff <= 1'b0;
            noise_flag_ff <= 1'b0;
            framing_flag_ff <= 1'b0;
            parity_fail_flag_ff <= 1'b0;
            idle_ff <= 1'b0;
            rx_buffer_ff <= 9'h000;
            idle_armed_ff <= 1'b1;
        end
        else
        begin
            if (rx_clear)
            begin
                rx_buffer_full_ff <= 1'b0;
                overrun_ff <= 1'b0;
                noise_flag_ff <= 1'b0;
                framing_flag_ff <= 1'b0;
                parity_fail_flag_ff <= 1'b0;
                idle_ff <= 1'b0;
            end
            if (flags_ok)
            begin
                rx_buffer_ff <= rx_sh_ff;
                rx_buffer_full_ff <= 1'b1;
                noise_flag_ff <= rx_noise_ff | hidden_noise_ff;
                framing_flag_ff <= stop_bad;
                parity_fail_flag_ff <= parity_bad && !(ctrl2_ff[`C2_MUTE]);
                idle_armed_ff <= 1'b1;
            end
            else if (accept && rx_buffer_full_ff && !ctrl2_ff[`C2_MUTE])
                overrun_ff <= 1'b1;
            if (rx_idle_done && !ctrl2_ff[`C2_MUTE])
            begin
                idle_ff <= 1'b1;
                idle_armed_ff <= 1'b0;
            end
        end
    end

    // control register two with hardware mute release
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            ctrl2_ff <= `RST_CTRL;
        else if (bus_i.wr && bus_i.addr == `OFS_CTRL2)
            ctrl2_ff <= bus_i.wdata;
        else if (mute_clear)
            ctrl2_ff[`C2_MUTE] <= 1'b0;
    end

    // transmitter
    logic tx_on_q_ff;
    logic tx_rise, tx_fall, txen;
    logic kind_data_ff, kind_break_ff;
    logic tail_due;
    assign txen = ctrl2_ff[`C2_TX_ON];
    assign tail_due = break_tail_ff || (tx_done && kind_break_ff && !ctrl2_ff[`C2_BREAK]);
    assign tx_rise = txen && !tx_on_q_ff;
    assign tx_fall = !txen && tx_on_q_ff;
    logic [8:0] tx_word;
    logic par_bit;
    always_comb
    begin
        tx_word = tx_buffer_ff;
        par_bit = ctrl1_ff[`C1_PAR_SENSE] ^ (word9 ? ^tx_buffer_ff[7:0] : ^tx_buffer_ff[6:0]);
        if (ctrl1_ff[`C1_PAR_ON])
        begin
            if (word9)
                tx_word[8] = par_bit;
            else
                tx_word[7] = par_bit;
        end
        tx_len = word9 ? 4'hB : 4'hA;
        tx_frame = 11'h7FF;
        tx_start = 1'b0;
        if ((!tx_busy || tx_done) && txen)
        begin
            if (tail_due)
            begin
                tx_frame = 11'h7FF;
                tx_len = 4'h1;
                tx_start = 1'b1;
            end
            else if (ctrl2_ff[`C2_BREAK])
            begin
                tx_frame = 11'h000;
                tx_start = 1'b1;
            end
            else if (idle_due_ff)
            begin
                tx_frame = 11'h7FF;
                tx_start = 1'b1;
            end
            else if (tx_pending_ff)
            begin
                tx_frame = word9 ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
                tx_start = 1'b1;
            end
        end
    end

    frame_tx u_shift (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .tick_i(tx_tick),
        .start_i(tx_start),
        .frame_i(tx_frame),
        .nbits_i(tx_len),
        .busy_o(tx_busy),
        .done_o(tx_done),
        .pin_o(serial_out_pin_o)
    );

    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            tx_on_q_ff <= 1'b0;
            idle_due_ff <= 1'b0;
            break_tail_ff <= 1'b0;
            kind_data_ff <= 1'b0;
            kind_break_ff <= 1'b0;
        end
        else
        begin
            tx_on_q_ff <= txen;
            if (tx_rise)
                idle_due_ff <= 1'b1;
            else if (tx_start && !ctrl2_ff[`C2_BREAK] && !tail_due)
                idle_due_ff <= 1'b0;
            if (tx_start)
            begin
                kind_data_ff <= !ctrl2_ff[`C2_BREAK] && !tail_due && !idle_due_ff;
                kind_break_ff <= ctrl2_ff[`C2_BREAK] && !tail_due;
            end
            if (tx_start && tail_due)
                break_tail_ff <= 1'b0;
            else if (tx_done && kind_break_ff && !ctrl2_ff[`C2_BREAK])
                break_tail_ff <= 1'b1;
        end
    end
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            tx_buffer_empty_ff <= 1'b1;
            tx_done_flag_ff <= 1'b1;
            tx_pending_ff <= 1'b0;
            tx_buffer_ff <= 9'h000;
        end
        else
        begin
            if (tx_clear)
            begin
                tx_buffer_empty_ff <= 1'b0;
                tx_done_flag_ff <= 1'b0;
            end
            if (wr_data)
            begin
                tx_buffer_ff <= {ctrl1_ff[`C1_T8], bus_i.wdata};
                tx_pending_ff <= 1'b1;
            end
            if (tx_fall)
                tx_pending_ff <= 1'b0;
            if (tx_start && kind_next_data())
            begin
                tx_pending_ff <= 1'b0;
                tx_buffer_empty_ff <= 1'b1;
            end
            if (tx_done && kind_data_ff)
                tx_done_flag_ff <= 1'b1;
        end
    end
    function automatic logic kind_next_data();
        kind_next_data = !ctrl2_ff[`C2_BREAK] && !tail_due && !idle_due_ff;
    endfunction

    // read port
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            rdata_ff <= 8'h00;
        else if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                `OFS_STATUS: rdata_ff <= {tx_buffer_empty_ff, tx_done_flag_ff, rx_buffer_full_ff, idle_ff,
                                          overrun_ff, noise_flag_ff, framing_flag_ff, parity_fail_flag_ff};
                `OFS_DATA: rdata_ff <= rx_buffer_ff[7:0];
                `OFS_BAUD: rdata_ff <= baud_ff;
                `OFS_CTRL1: rdata_ff <= {rx_buffer_ff[8], ctrl1_ff[6:0]};
                `OFS_CTRL2: rdata_ff <= ctrl2_ff;
                `OFS_TXFINE: rdata_ff <= txfine_ff;
                `OFS_RXFINE: rdata_ff <= rxfine_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end
    assign rdata_o = rdata_ff;

    assign irq_o = (ctrl2_ff[`C2_TXE_IRQ] && tx_buffer_empty_ff) || (ctrl2_ff[`C2_TC_IRQ] && tx_done_flag_ff) ||
                   (!ctrl2_ff[`C2_MUTE] && ((ctrl2_ff[`C2_RX_IRQ] && (rx_buffer_full_ff || overrun_ff)) ||
                   (ctrl2_ff[`C2_IDLE_IRQ] && idle_ff) || (ctrl1_ff[`C1_PAR_IRQ] && parity_fail_flag_ff)));

    chk_clear_tx: assert property (@(posedge clock_i) disable iff (!rstn_i)
        tx_clear && !tx_start && !tx_done |=> !tx_done_flag_ff) else $error("tx flags not cleared");
    chk_clear_rx: assert property (@(posedge clock_i) disable iff (!rstn_i)
        rx_clear && !accept |=> !rx_buffer_full_ff && !overrun_ff) else $error("rx flags not cleared");
    chk_overrun_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
        accept && rx_buffer_full_ff && !rx_clear |=> $stable(rx_buffer_ff)) else $error("buffer lost on overrun");
    chk_full_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
        flags_ok |=> rx_buffer_full_ff && rx_buffer_ff == $past(rx_sh_ff)) else $error("buffer not loaded");
    chk_break_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
        tx_start && ctrl2_ff[`C2_BREAK] && !tail_due |=> !serial_out_pin_o) else $error("break not low");
    chk_idle_first: assert property (@(posedge clock_i) disable iff (!rstn_i)
        tx_rise |=> idle_due_ff) else $error("idle not scheduled");
    chk_mute_flags: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ctrl2_ff[`C2_MUTE] && !mute_clear && !rx_buffer_full_ff && !rx_clear && !bus_i.wr |=> !rx_buffer_full_ff)
        else $error("flag set while muted");
    chk_idle_tx: assert property (@(posedge clock_i) disable iff (!rstn_i)
        tx_fall |=> !tx_pending_ff) else $error("buffer kept over toggle");
    cov_rx_char: cover property (@(posedge clock_i) flags_ok);
    cov_overrun: cover property (@(posedge clock_i) overrun_ff);
    cov_break: cover property (@(posedge clock_i) break_tail_ff);
endmodule

// [testbench/serial_partner.sv]
// far-end serial equipment: sends and captures 8-bit frames
// assumes the unit keeps its reset rate, 16 clock_i cycles a bit
`timescale 1ns/100ps
module serial_partner (
    input wire logic clock_i,
    input wire logic line_i,
    output logic line_o
);
    // line idles at mark level
    initial line_o = 1'b1;
    // frame bits go out lsb first: start, data, stop
    task automatic send(input logic [9:0] frame);
        for (int i = 0; i < 10; i++)
        begin
            line_o <= frame[i];
            repeat (16) @(posedge clock_i);
        end
    endtask
    // gap counts mark cycles before the start edge
    task automatic recv(output logic [7:0] data, output int gap);
        gap = 0;
        while (tx_high() && gap < 2000)
        begin
            @(posedge clock_i);
            gap++;
        end
        repeat (8) @(posedge clock_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(posedge clock_i);
            data[i] = line_i;
        end
    endtask
    function automatic logic tx_high();
        return line_i !== 1'b0;
    endfunction
endmodule

// [testbench/async_serial_unit_tb_top.sv]
// self-checking bench of async_serial_unit with a serial line partner
// assumes baud registers stay at reset, so one bit is 16 cycles
`timescale 1ns/100ps
module async_serial_unit_tb_top;
    logic clock_i;
    logic rstn_i;
    serial_pkg::bus_req_t bus;
    logic [7:0] rdata;
    logic rx_line;
    logic tx_line;
    logic irq;
    int failures;
    int n_checks;
    int cyc;
    async_serial_unit async_serial_unit_inst (.clock_i(clock_i), .rstn_i(rstn_i), .bus_i(bus),
        .rdata_o(rdata), .serial_in_pin_i(rx_line), .serial_out_pin_o(tx_line), .irq_o(irq));
    serial_partner serial_partner_inst (.clock_i(clock_i), .line_i(tx_line), .line_o(rx_line));
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    // an idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus <= '0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus <= '0;
        @(posedge clock_i);
        d = rdata;
    endtask
    task automatic flush();
        logic [7:0] d;
        rd(3'h0, d);
        rd(3'h1, d);
    endtask
    task automatic t_reset();
        logic [7:0] d;
        rd(3'h0, d);
        check(d, 8'hC0);
        rd(3'h7, d);
        check(d, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_tx();
        logic [7:0] d;
        int gap;
        wr(3'h3, 8'h06);
        wr(3'h4, 8'h08);
        rd(3'h0, d);
        wr(3'h1, 8'h35);
        rd(3'h0, d);
        check(d & 8'hC0, 8'h00);
        serial_partner_inst.recv(d, gap);
        check(8'(gap > 140), 8'h01);
        check(d, 8'hB5);
        repeat (40) @(posedge clock_i);
        rd(3'h0, d);
        check(d & 8'h40, 8'h40);
        wr(3'h3, 8'h00);
        $display("transmit test done");
    endtask
    task automatic t_rx();
        logic [7:0] d;
        wr(3'h4, 8'h2C);
        flush();
        serial_partner_inst.send({1'b1, 8'h5A, 1'b0});
        check({7'h00, irq}, 8'h01);
        rd(3'h0, d);
        check(d & 8'h2F, 8'h20);
        rd(3'h1, d);
        check(d, 8'h5A);
        rd(3'h0, d);
        check(d & 8'h20, 8'h00);
        $display("receive test done");
    endtask
    task automatic t_over();
        logic [7:0] d;
        flush();
        serial_partner_inst.send({1'b1, 8'h11, 1'b0});
        serial_partner_inst.send({1'b1, 8'h22, 1'b0});
        rd(3'h0, d);
        check(d & 8'h28, 8'h28);
        rd(3'h1, d);
        check(d, 8'h11);
        rd(3'h0, d);
        check(d & 8'h08, 8'h00);
        $display("overrun test done");
    endtask
    task automatic t_pmute();
        logic [7:0] d;
        wr(3'h3, 8'h04);
        flush();
        serial_partner_inst.send({1'b1, 8'h01, 1'b0});
        rd(3'h0, d);
        check(d & 8'h21, 8'h21);
        rd(3'h1, d);
        check(d, 8'h01);
        wr(3'h3, 8'h08);
        wr(3'h4, 8'h2E);
        flush();
        serial_partner_inst.send({1'b1, 8'h11, 1'b0});
        rd(3'h0, d);
        check(d & 8'h20, 8'h00);
        serial_partner_inst.send({1'b1, 8'h91, 1'b0});
        rd(3'h4, d);
        check(d & 8'h02, 8'h00);
        rd(3'h0, d);
        check(d & 8'h20, 8'h20);
        rd(3'h1, d);
        check(d, 8'h91);
        wr(3'h3, 8'h00);
        $display("parity and mute test done");
    endtask
    task automatic t_frame();
        logic [7:0] d;
        flush();
        serial_partner_inst.send(10'h000);
        serial_partner_inst.line_o <= 1'b1;
        rd(3'h0, d);
        check(d & 8'h22, 8'h22);
        rd(3'h1, d);
        check(d, 8'h00);
        $display("framing test done");
    endtask
    task automatic t_break();
        int n;
        int lvl;
        wr(3'h4, 8'h2D);
        for (n = 0; tx_line !== 1'b0 && n < 400; n++)
            @(posedge clock_i);
        lvl = 0;
        repeat (320) @(posedge clock_i) lvl += (tx_line === 1'b0);
        check(8'(lvl == 320), 8'h01);
        wr(3'h4, 8'h2C);
        for (n = 0; tx_line !== 1'b1 && n < 400; n++)
            @(posedge clock_i);
        lvl = 0;
        repeat (16) @(posedge clock_i) lvl += (tx_line === 1'b1);
        check(8'(lvl == 16), 8'h01);
        $display("break test done");
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // whole run is near 2000 cycles; the ceiling leaves ample room
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            conclude();
        end
    end
    // baud left at reset value throughout, never touched while enabled
    initial
    begin
        rstn_i = 1'b0;
        bus = '0;
        repeat (12) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_over();
        t_pmute();
        t_frame();
        t_break();
        conclude();
    end
endmodule
